// File: src/bcs_pkg.sv
// Package for the battery charge sequencer: register map, field layout,
// states, ratios and timing constants.
// Assumes a 25 MHz APB clock and a 1 us timer tick.
package bcs_pkg;

    // ********************
    // Register map
    // ********************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_AC_SET = 8'h04;
    localparam logic [7:0] ADDR_USB_SET = 8'h08;
    localparam logic [7:0] ADDR_TMAX = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_ST = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam int CTRL_EN_BIT = 0;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_TIMEOUT = 1;
    localparam int IRQ_THERM = 2;
    localparam int IRQ_PRE_TIMEOUT = 3;
    localparam logic [31:0] TMAX_RST = 32'h0000_0e10;

    // ********************
    // Ratios and timing
    // ********************
    localparam int PRE_DIV = 10;
    localparam int LP_DIV = 5;
    localparam int LP_TIME_MUL = 5;
    localparam int DEGLITCH_DIV = 220;
    localparam int PRE_TIME_SHIFT = 3;
    localparam int CLK_NS = 40;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = (TICK_US * 1000 + CLK_NS - 1) / CLK_NS;

    // ********************
    // Types
    // ********************
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_PRE = 7'h02,
        ST_FAST = 7'h04,
        ST_CV = 7'h08,
        ST_DONE = 7'h10,
        ST_FAULT = 7'h20,
        ST_THERM = 7'h40
    } bcs_state_t;

    // Comparator and mode pins, all asynchronous to pclk
    typedef struct packed {
        logic supply_ok;
        logic mode_usb;
        logic usb_power_level_select;
        logic above_precharge;
        logic near_regulation;
        logic below_termination;
        logic below_recharge;
        logic thermistor_out;
    } bcs_pins_t;

endpackage

// File: src/bcs_charge_sequencer.sv
// Charge sequencer for a single-cell lithium charger: phase control,
// current selection, termination, recharge, safety timers, APB registers.
// Assumes comparator pins asynchronous to pclk, a 25 MHz pclk, and an
// analog stage that follows the current command and regulation flag.
//
// The register addresses and register access over APB were chosen for this implementation.

module bcs_charge_sequencer #(
    parameter int CUR_W = 10,
    parameter int TICK_DIV = bcs_pkg::TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire bcs_pkg::bcs_pins_t pins,
    output logic charge_on,
    output logic regulate_voltage,
    output logic [CUR_W-1:0] current_cmd,
    output logic status_out_a_oe,
    output logic status_out_b_oe,
    output logic irq
);

    // ********************
    // Parameter checks
    // ********************
    generate
        if (CUR_W < 4 || CUR_W > 16) begin : g_bad_w
            $error("CUR_W must be 4 to 16");
        end
        if (TICK_DIV < 1 || TICK_DIV > 4096) begin : g_bad_div
            $error("TICK_DIV must be 1 to 4096");
        end
    endgenerate

    // ********************
    // Pin synchronisers
    // ********************
    bcs_pkg::bcs_pins_t pin_meta;
    bcs_pkg::bcs_pins_t pin_s;

    // Two stages; only the second stage is read by logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '0;
            pin_s <= '0;
        end else begin
            pin_meta <= pins;
            pin_s <= pin_meta;
        end
    end

    // ********************
    // Registers
    // ********************
    logic ctrl_en;
    logic [CUR_W-1:0] ac_set;
    logic [CUR_W-1:0] usb_set;
    logic [31:0] tmax;
    logic [bcs_pkg::IRQ_W-1:0] irq_st;
    logic [bcs_pkg::IRQ_W-1:0] irq_mask;
    bcs_pkg::bcs_state_t state;
    bcs_pkg::bcs_state_t next_state;

    // APB decode; one wait state, pready registered
    wire acc = psel && penable && !pready;
    wire wr_done = psel && penable && pready && pwrite;
    wire hit_ctrl = paddr == bcs_pkg::ADDR_CTRL;
    wire hit_ac = paddr == bcs_pkg::ADDR_AC_SET;
    wire hit_usb = paddr == bcs_pkg::ADDR_USB_SET;
    wire hit_tmax = paddr == bcs_pkg::ADDR_TMAX;
    wire hit_stat = paddr == bcs_pkg::ADDR_STATUS;
    wire hit_ist = paddr == bcs_pkg::ADDR_IRQ_ST;
    wire hit_imask = paddr == bcs_pkg::ADDR_IRQ_MASK;
    wire hit_any = hit_ctrl | hit_ac | hit_usb | hit_tmax | hit_stat | hit_ist | hit_imask;
    wire [31:0] stat_word = {17'h0, pin_s, state};
    wire [31:0] rd_mux =
        hit_ctrl ? {31'h0, ctrl_en} :
        hit_ac ? {{(32 - CUR_W){1'b0}}, ac_set} :
        hit_usb ? {{(32 - CUR_W){1'b0}}, usb_set} :
        hit_tmax ? tmax :
        hit_stat ? stat_word :
        hit_ist ? {28'h0, irq_st} :
        hit_imask ? {28'h0, irq_mask} : 32'h0;

    // Bus answer: data, ready and error all from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= acc;
            pslverr <= acc && !hit_any;
            prdata <= (acc && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // Software settings; writes land at the completing edge only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en <= 1'b0;
            ac_set <= '0;
            usb_set <= '0;
            tmax <= bcs_pkg::TMAX_RST;
            irq_mask <= '0;
        end else if (wr_done) begin
            if (hit_ctrl) ctrl_en <= pwdata[bcs_pkg::CTRL_EN_BIT];
            if (hit_ac) ac_set <= pwdata[CUR_W-1:0];
            if (hit_usb) usb_set <= pwdata[CUR_W-1:0];
            if (hit_tmax) tmax <= pwdata;
            if (hit_imask) irq_mask <= pwdata[bcs_pkg::IRQ_W-1:0];
        end
    end

    // ********************
    // Current selection
    // ********************
    wire usb_lp = pin_s.mode_usb && !pin_s.usb_power_level_select;
    wire [CUR_W-1:0] usb_cur = usb_lp ? CUR_W'(usb_set / bcs_pkg::LP_DIV) : usb_set;
    wire [CUR_W-1:0] fast_cur = pin_s.mode_usb ? usb_cur : ac_set;
    wire [CUR_W-1:0] pre_cur = CUR_W'(fast_cur / bcs_pkg::PRE_DIV);

    // ********************
    // Timebase and limits
    // ********************
    logic [11:0] presc;
    logic tick;
    logic [34:0] timer;
    logic [34:0] dg_cnt;

    // Slow tick enable keeps a 35-bit count good for hours
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc <= '0;
            tick <= 1'b0;
        end else begin
            tick <= presc == 12'(TICK_DIV - 1);
            presc <= (presc == 12'(TICK_DIV - 1)) ? 12'h0 : presc + 12'h1;
        end
    end

    // Low power USB stretches every derived interval
    wire [34:0] lim_max = usb_lp ? 35'(tmax) * 35'(bcs_pkg::LP_TIME_MUL) : 35'(tmax);
    wire [34:0] lim_pre = lim_max >> bcs_pkg::PRE_TIME_SHIFT;
    wire [34:0] lim_dg = lim_max / 35'(bcs_pkg::DEGLITCH_DIV);
    wire go = ctrl_en && pin_s.supply_ok;
    wire pre_exp = timer >= lim_pre;
    wire max_exp = timer >= lim_max;
    wire dg_exp = dg_cnt >= lim_dg;
    wire tmr_clr = next_state != state && (next_state == bcs_pkg::ST_PRE ||
                                           next_state == bcs_pkg::ST_FAST);
    wire tmr_run = state == bcs_pkg::ST_PRE || state == bcs_pkg::ST_FAST ||
                   state == bcs_pkg::ST_CV;

    // Safety timer restarts when pre-charge or fast charge begins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer <= '0;
        end else if (tmr_clr) begin
            timer <= '0;
        end else if (tmr_run && tick && !max_exp) begin
            timer <= timer + 35'h1;
        end
    end

    // Low-current deglitch; any excursion above restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dg_cnt <= '0;
        end else if (state != bcs_pkg::ST_CV || !pin_s.below_termination) begin
            dg_cnt <= '0;
        end else if (tick && !dg_exp) begin
            dg_cnt <= dg_cnt + 35'h1;
        end
    end

    // ********************
    // Phase sequencer
    // ********************
    // Disable and supply loss win, then thermistor; timers rank below the phase comparators except in fast charge
    always_comb begin
        next_state = state;
        if (!go) begin
            next_state = bcs_pkg::ST_IDLE;
        end else begin
            case (state)
                bcs_pkg::ST_IDLE: begin
                    if (pin_s.thermistor_out) next_state = bcs_pkg::ST_THERM;
                    else if (pin_s.above_precharge) next_state = bcs_pkg::ST_FAST;
                    else next_state = bcs_pkg::ST_PRE;
                end
                bcs_pkg::ST_PRE: begin
                    if (pin_s.thermistor_out) next_state = bcs_pkg::ST_THERM;
                    else if (pin_s.above_precharge) next_state = bcs_pkg::ST_FAST;
                    else if (pre_exp) next_state = bcs_pkg::ST_FAULT;
                end
                bcs_pkg::ST_FAST: begin
                    if (pin_s.thermistor_out) next_state = bcs_pkg::ST_THERM;
                    else if (max_exp) next_state = bcs_pkg::ST_FAULT;
                    else if (pin_s.near_regulation) next_state = bcs_pkg::ST_CV;
                end
                bcs_pkg::ST_CV: begin
                    if (pin_s.thermistor_out) next_state = bcs_pkg::ST_THERM;
                    else if (dg_exp && pin_s.below_termination) next_state = bcs_pkg::ST_DONE;
                    else if (max_exp) next_state = bcs_pkg::ST_FAULT;
                end
                bcs_pkg::ST_DONE: begin
                    if (pin_s.thermistor_out) next_state = bcs_pkg::ST_THERM;
                    else if (pin_s.below_recharge) next_state = bcs_pkg::ST_IDLE;
                end
                bcs_pkg::ST_THERM: begin
                    if (!pin_s.thermistor_out) next_state = bcs_pkg::ST_IDLE;
                end
                bcs_pkg::ST_FAULT: next_state = bcs_pkg::ST_FAULT;
                default: next_state = bcs_pkg::ST_IDLE;
            endcase
        end
    end

    // Fault latches until software drops the enable or supply_ok falls
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) state <= bcs_pkg::ST_IDLE;
        else state <= next_state;
    end

    // ********************
    // Interrupts
    // ********************
    wire entering = next_state != state;
    wire [bcs_pkg::IRQ_W-1:0] ev = {
        entering && next_state == bcs_pkg::ST_FAULT && state == bcs_pkg::ST_PRE,
        entering && next_state == bcs_pkg::ST_THERM,
        entering && next_state == bcs_pkg::ST_FAULT && state != bcs_pkg::ST_PRE,
        entering && next_state == bcs_pkg::ST_DONE
    };
    wire [bcs_pkg::IRQ_W-1:0] w1c = (wr_done && hit_ist) ? pwdata[bcs_pkg::IRQ_W-1:0] : '0;
    wire [bcs_pkg::IRQ_W-1:0] next_irq_st = (irq_st & ~w1c) | ev;

    // A new event outranks a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st <= '0;
            irq <= 1'b0;
        end else begin
            irq_st <= next_irq_st;
            irq <= |(next_irq_st & irq_mask);
        end
    end

    // ********************
    // Analog commands and status pins
    // ********************
    wire in_pre = next_state == bcs_pkg::ST_PRE;
    wire in_chg = in_pre || next_state == bcs_pkg::ST_FAST || next_state == bcs_pkg::ST_CV;
    wire in_done = next_state == bcs_pkg::ST_DONE;
    wire in_therm = next_state == bcs_pkg::ST_THERM;

    // Registered from the next state so pins move with the phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charge_on <= 1'b0;
            regulate_voltage <= 1'b0;
            current_cmd <= '0;
            status_out_a_oe <= 1'b0;
            status_out_b_oe <= 1'b0;
        end else begin
            charge_on <= in_chg;
            regulate_voltage <= next_state == bcs_pkg::ST_CV;
            current_cmd <= !in_chg ? '0 : in_pre ? pre_cur : fast_cur;
            status_out_a_oe <= in_chg || in_therm;
            status_out_b_oe <= in_done || in_therm;
        end
    end

    // ********************
    // Assertions
    // ********************
    property p_pre_entry;
        @(posedge pclk) disable iff (!presetn)
        state == bcs_pkg::ST_IDLE && go && !pin_s.thermistor_out && !pin_s.above_precharge
        |=> state == bcs_pkg::ST_PRE && current_cmd == $past(pre_cur);
    endproperty
    a_pre_entry: assert property (p_pre_entry) else $error("no pre-charge entry");

    property p_skip_pre;
        @(posedge pclk) disable iff (!presetn)
        state == bcs_pkg::ST_IDLE && go && !pin_s.thermistor_out && pin_s.above_precharge
        |=> state == bcs_pkg::ST_FAST && timer == 35'h0;
    endproperty
    a_skip_pre: assert property (p_skip_pre) else $error("pre-charge not skipped");

    property p_ac_sel;
        @(posedge pclk) disable iff (!presetn)
        next_state == bcs_pkg::ST_FAST && !pin_s.mode_usb |=> current_cmd == $past(ac_set);
    endproperty
    a_ac_sel: assert property (p_ac_sel) else $error("adapter current wrong");

    property p_usb_lp;
        @(posedge pclk) disable iff (!presetn)
        next_state == bcs_pkg::ST_FAST && usb_lp
        |=> current_cmd == $past(CUR_W'(usb_set / bcs_pkg::LP_DIV));
    endproperty
    a_usb_lp: assert property (p_usb_lp) else $error("low power current wrong");

    property p_cv_entry;
        @(posedge pclk) disable iff (!presetn)
        state == bcs_pkg::ST_FAST && go && !pin_s.thermistor_out && !max_exp &&
        pin_s.near_regulation |=> state == bcs_pkg::ST_CV && regulate_voltage;
    endproperty
    a_cv_entry: assert property (p_cv_entry) else $error("no regulation phase");

    property p_done;
        @(posedge pclk) disable iff (!presetn)
        state == bcs_pkg::ST_DONE |-> !status_out_a_oe && status_out_b_oe;
    endproperty
    a_done: assert property (p_done) else $error("done status wrong");

    property p_deglitch;
        @(posedge pclk) disable iff (!presetn)
        $rose(state == bcs_pkg::ST_DONE) |-> $past(dg_cnt) >= $past(lim_dg);
    endproperty
    a_deglitch: assert property (p_deglitch) else $error("done before deglitch");

    property p_recharge;
        @(posedge pclk) disable iff (!presetn)
        state == bcs_pkg::ST_DONE && go && !pin_s.thermistor_out && pin_s.below_recharge
        |=> ##1 state inside {bcs_pkg::ST_PRE, bcs_pkg::ST_FAST};
    endproperty
    a_recharge: assert property (p_recharge) else $error("no recharge");

    property p_timeout;
        @(posedge pclk) disable iff (!presetn)
        state == bcs_pkg::ST_FAST && go && !pin_s.thermistor_out && max_exp
        |=> state == bcs_pkg::ST_FAULT ##1 !charge_on;
    endproperty
    a_timeout: assert property (p_timeout) else $error("max timer fault missed");

    property p_therm;
        @(posedge pclk) disable iff (!presetn)
        go && pin_s.thermistor_out && state != bcs_pkg::ST_FAULT
        |=> !charge_on && status_out_a_oe && status_out_b_oe;
    endproperty
    a_therm: assert property (p_therm) else $error("thermal halt missed");

endmodule

// File: tb/bcs_charger_model.sv
// Behavioural model of the analog power stage and its comparators.
// Assumes the bench sets battery voltage, supply, mode pins and taper state.
module bcs_charger_model #(
    parameter int END_MA = 16,
    parameter int PRE_MV = 3000,
    parameter int NEAR_MV = 4150,
    parameter int RCH_MV = 4050
) (
    input wire logic pclk,
    input wire logic charge_on,
    input wire logic regulate_voltage,
    input wire logic [9:0] current_cmd,
    input wire logic supply_ok,
    input wire logic mode_usb,
    input wire logic power_high,
    input wire logic thermistor_out,
    input wire logic taper_done,
    input wire logic [15:0] vbat_mv,
    output bcs_pkg::bcs_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sensed current: zero when idle, collapses once the taper ends
    logic [9:0] sensed;
    assign sensed = (!charge_on || (regulate_voltage && taper_done)) ? 10'h000 : current_cmd;

    // Comparators settle one clock late, like a slow analog front end
    always_ff @(posedge pclk) begin
        pins.supply_ok <= supply_ok;
        pins.mode_usb <= mode_usb;
        pins.usb_power_level_select <= power_high;
        pins.above_precharge <= (vbat_mv >= 16'(PRE_MV));
        pins.near_regulation <= (vbat_mv >= 16'(NEAR_MV));
        pins.below_termination <= (sensed < 10'(END_MA));
        pins.below_recharge <= (vbat_mv < 16'(RCH_MV));
        pins.thermistor_out <= thermistor_out;
    end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the charge sequencer, APB master and pin stimulus.
// Assumes the sequencer answers APB with one wait state and TICK_DIV of 1.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    bcs_pkg::bcs_pins_t pins;
    logic charge_on, regulate_voltage, status_out_a_oe, status_out_b_oe, irq;
    logic [9:0] current_cmd;
    logic supply_ok, mode_usb, power_high, therm, taper_done;
    logic [15:0] vbat_mv;
    logic [3:0] outs;
    int errors, checks;
    assign outs = {charge_on, regulate_voltage, status_out_a_oe, status_out_b_oe};

    always #20 pclk = ~pclk;

    bcs_charge_sequencer #(.CUR_W(10), .TICK_DIV(1)) bcs_charge_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .charge_on(charge_on),
        .regulate_voltage(regulate_voltage), .current_cmd(current_cmd),
        .status_out_a_oe(status_out_a_oe), .status_out_b_oe(status_out_b_oe), .irq(irq));

    bcs_charger_model bcs_charger_model_i (
        .pclk(pclk), .charge_on(charge_on), .regulate_voltage(regulate_voltage),
        .current_cmd(current_cmd), .supply_ok(supply_ok), .mode_usb(mode_usb),
        .power_high(power_high), .thermistor_out(therm), .taper_done(taper_done),
        .vbat_mv(vbat_mv), .pins(pins));

    // ********************
    // Shared tasks
    // ********************
    task automatic print_verdict;
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (exp !== got) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("[ERR] pready expected 1 seen 0");
            print_verdict();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                      input string name);
        apb(1'b0, a, 32'h0000_0000);
        check(name, exp, rdat & m);
    endtask

    // Bounded wait for the output pattern {charge, regulate, a_oe, b_oe}
    task automatic wait_out(input string name, input logic [3:0] exp, input int lim);
        int n;
        n = 0;
        while (outs !== exp && n < lim) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check(name, 32'(exp), 32'(outs));
    endtask

    // Restart a charge: disable clears faults, pins settle before enable
    task automatic start(input logic usb, input logic hi, input logic [15:0] mv);
        apb(1'b1, bcs_pkg::ADDR_CTRL, 32'h0000_0000);
        @(posedge pclk);
        mode_usb <= usb;
        power_high <= hi;
        vbat_mv <= mv;
        taper_done <= 1'b0;
        apb(1'b1, bcs_pkg::ADDR_IRQ_ST, 32'h0000_000f);
        apb(1'b1, bcs_pkg::ADDR_CTRL, 32'h0000_0001);
    endtask

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset;
        rd(bcs_pkg::ADDR_TMAX, bcs_pkg::TMAX_RST, 32'hffff_ffff, "tmax_rst");
        rd(bcs_pkg::ADDR_CTRL, 32'h0, 32'hffff_ffff, "ctrl_rst");
        rd(bcs_pkg::ADDR_IRQ_MASK, 32'h0, 32'hffff_ffff, "mask_rst");
        rd(bcs_pkg::ADDR_STATUS, 32'h01, 32'h7f, "state_rst");
        rd(8'h1c, 32'h0, 32'hffff_ffff, "unmapped_data");
        check("unmapped_err", 32'h1, 32'(rerr));
    endtask

    // Source selection for adapter, USB high and USB low power
    task automatic t_modes;
        logic [9:0] exp [3];
        exp = '{10'd200, 10'd300, 10'd60};
        for (int i = 0; i < 3; i++) begin
            start(i > 0, i == 1, 16'd3500);
            wait_out("fast_direct", 4'b1010, 12);
            check("fast_cur", 32'(exp[i]), 32'(current_cmd));
        end
        @(posedge pclk);
        supply_ok <= 1'b0;
        wait_out("standby", 4'b0000, 8);
        @(posedge pclk);
        supply_ok <= 1'b1;
    endtask

    task automatic t_pre;
        start(1'b0, 1'b1, 16'd2500);
        wait_out("pre", 4'b1010, 12);
        check("pre_cur", 32'd20, 32'(current_cmd));
        vbat_mv <= 16'd3500;
        repeat (8) @(posedge pclk);
        #1;
        check("pre_to_fast_cur", 32'd200, 32'(current_cmd));
    endtask

    // Pre-charge timer of 80/8 ticks, then interrupt mask and clear
    task automatic t_pre_timeout;
        apb(1'b1, bcs_pkg::ADDR_TMAX, 32'd80);
        start(1'b0, 1'b1, 16'd2500);
        wait_out("pre2", 4'b1010, 12);
        wait_out("pre_fault", 4'b0000, 24);
        rd(bcs_pkg::ADDR_IRQ_ST, 32'h8, 32'hf, "pre_irq_st");
        check("irq_masked", 32'h0, 32'(irq));
        apb(1'b1, bcs_pkg::ADDR_IRQ_MASK, 32'h0000_000f);
        @(posedge pclk);
        #1;
        check("irq_on", 32'h1, 32'(irq));
        apb(1'b1, bcs_pkg::ADDR_IRQ_ST, 32'h0000_0008);
        @(posedge pclk);
        #1;
        check("irq_cleared", 32'h0, 32'(irq));
    endtask

    // Max timer of 80 ticks, five times longer in low-power USB
    task automatic t_max_timer;
        start(1'b0, 1'b1, 16'd3500);
        wait_out("fast_t", 4'b1010, 12);
        repeat (60) @(posedge pclk);
        #1;
        check("fast_hold", 32'h0a, 32'(outs));
        wait_out("max_fault", 4'b0000, 30);
        rd(bcs_pkg::ADDR_IRQ_ST, 32'h2, 32'hf, "max_irq_st");
        start(1'b1, 1'b0, 16'd3500);
        wait_out("fast_lp", 4'b1010, 12);
        repeat (300) @(posedge pclk);
        #1;
        check("lp_hold", 32'h0a, 32'(outs));
        wait_out("lp_fault", 4'b0000, 120);
    endtask

    // Regulation, deglitched termination of 2200/220 ticks, recharge
    task automatic t_full;
        apb(1'b1, bcs_pkg::ADDR_TMAX, 32'd2200);
        start(1'b0, 1'b1, 16'd4170);
        wait_out("cv", 4'b1110, 14);
        taper_done <= 1'b1;
        repeat (4) @(posedge pclk);
        taper_done <= 1'b0;
        repeat (20) @(posedge pclk);
        #1;
        check("glitch_kept", 32'h0e, 32'(outs));
        taper_done <= 1'b1;
        repeat (8) @(posedge pclk);
        #1;
        check("deglitch_wait", 32'h0e, 32'(outs));
        wait_out("done", 4'b0001, 12);
        rd(bcs_pkg::ADDR_IRQ_ST, 32'h1, 32'hf, "done_irq_st");
        vbat_mv <= 16'd4000;
        wait_out("recharge", 4'b1010, 14);
    endtask

    task automatic t_therm;
        start(1'b0, 1'b1, 16'd3500);
        wait_out("fast_hot", 4'b1010, 12);
        therm <= 1'b1;
        wait_out("therm", 4'b0011, 8);
        rd(bcs_pkg::ADDR_IRQ_ST, 32'h4, 32'hf, "therm_irq_st");
        therm <= 1'b0;
        wait_out("therm_resume", 4'b1010, 14);
    endtask

    // ********************
    // Main sequence
    // ********************
    initial begin
        errors = 0;
        checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        supply_ok = 1'b1;
        mode_usb = 1'b0;
        power_high = 1'b1;
        therm = 1'b0;
        taper_done = 1'b0;
        vbat_mv = 16'd3500;
        repeat (9) @(posedge pclk);
        #1;
        check("outs_rst", 32'h0, {17'h0, outs, irq, current_cmd});
        @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        apb(1'b1, bcs_pkg::ADDR_AC_SET, 32'd200);
        apb(1'b1, bcs_pkg::ADDR_USB_SET, 32'd300);
        apb(1'b1, bcs_pkg::ADDR_TMAX, 32'h0000_1000);
        t_modes();
        t_pre();
        t_pre_timeout();
        t_max_timer();
        t_full();
        t_therm();
        print_verdict();
    end
endmodule
